// ===== include/nbp_pkg.sv
// Purpose: Shared constants for the nibble port pin logic.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Pin sample vector layout is shared by the top and its checks.
package nbp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_NIB_CTRL = 8'h00;
  localparam logic [7:0] OFF_C_DIR    = 8'h04;
  localparam logic [7:0] OFF_D_CTRL   = 8'h08;
  localparam logic [7:0] OFF_DATA_OUT = 8'h0c;
  localparam logic [7:0] OFF_PIN_IN   = 8'h10;
  localparam logic [7:0] OFF_EVENT    = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NIB_DIR_LSB = 0;
  localparam int NIB_PU_LSB  = 4;
  localparam int D_DIR_LSB   = 0;
  localparam int D_PU_LSB    = 4;
  localparam int D_ALT_LSB   = 8;
  localparam int ALT_SCK     = 0;
  localparam int ALT_SO      = 1;
  localparam int ALT_SI      = 2;
  localparam int ALT_TM1     = 3;
  localparam int EVT_REL     = 0;
  localparam int EVT_INT     = 1;
  // ----------------------------------------------------------------
  // Sampled pin vector: a, b, c, d, e, f, int, hv detectors, clk
  // ----------------------------------------------------------------
  localparam int SY_W    = 26;
  localparam int SY_A    = 0;
  localparam int SY_B    = 4;
  localparam int SY_C    = 8;
  localparam int SY_D    = 12;
  localparam int SY_E    = 16;
  localparam int SY_F    = 20;
  localparam int SY_INT  = 22;
  localparam int SY_HVR  = 23;
  localparam int SY_HVP  = 24;
  localparam int SY_PCLK = 25;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  RST_NIB  = 3'h0;
  localparam logic [3:0]  RST_BITS = 4'h0;
  localparam logic [19:0] RST_DOUT = 20'h00000;
  // ----------------------------------------------------------------
  // Program memory mode codes as {md3, md2, md1, md0}
  // ----------------------------------------------------------------
  localparam int          PROM_AW    = 12;
  localparam logic [3:0]  MD_CLEAR   = 4'h5;
  localparam logic [3:0]  MD_WRITE   = 4'he;
  localparam logic [3:0]  MD_VERIFY  = 4'hc;
  localparam logic [3:0]  MD_INH_MSK = 4'hd;
  localparam logic [3:0]  MD_INHIBIT = 4'hd;
  localparam logic [1:0]  CLK_PER_ADDR_M1 = 2'h3;
endpackage

// ===== include/nbp_prog_if.sv
// Purpose: Link between the pin logic and the program memory control.
// Assumes: Single clock, sys_clk.
// Notes:   The top drives the request side, the control the answer side.
`timescale 1ns/100ps
interface nbp_prog_if;
  logic        en;
  logic [3:0]  md;
  logic        clk_lvl;
  logic [7:0]  bus_in;
  logic [7:0]  bus_out;
  logic        bus_oe;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic        re;
  modport top (output en, md, clk_lvl, bus_in,
               input bus_out, bus_oe, addr, wdata, we, re);
  modport ctl (input en, md, clk_lvl, bus_in,
               output bus_out, bus_oe, addr, wdata, we, re);
endinterface

// ===== hdl/nbp_prog_ctl.sv
// Purpose: Program memory write/verify control behind the port pins.
// Assumes: Inputs arrive already synchronised to sys_clk.
// Notes:   The address advances once per four address clock pulses.
`timescale 1ns/100ps
module nbp_prog_ctl
  import nbp_pkg::*;
(
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  arst_n,
  // Link to the pin logic
  nbp_prog_if.ctl    pif,
  // Program memory read data
  input  wire logic [7:0] prom_rdata
);
  typedef struct packed {
    logic         clk_prev;
    logic [1:0]   cnt;
    logic [11:0]  addr;
    logic [3:0]   md_prev;
    logic         we;
    logic         re;
    logic [7:0]   wdata;
    logic [7:0]   bus_out;
    logic         bus_oe;
  } nbp_ctl_type;

  nbp_ctl_type q, d;
  logic rise;

  always_comb begin
    d = q;
    rise = pif.clk_lvl & ~q.clk_prev;
    d.clk_prev = pif.clk_lvl;
    d.md_prev = pif.md;
    d.we = 1'b0;
    d.re = 1'b0;
    d.bus_oe = 1'b0;
    if (!pif.en) begin
      d.cnt = 2'h0;
      d.addr = '0;
    end else if (pif.md == MD_CLEAR) begin
      d.cnt = 2'h0;
      d.addr = '0;
    end else if (rise) begin
      d.cnt = q.cnt + 2'h1;
      if (q.cnt == CLK_PER_ADDR_M1) begin
        d.addr = q.addr + 12'h001;
      end
    end
    if (pif.en && pif.md == MD_WRITE) begin
      d.wdata = pif.bus_in;
      d.we = (q.md_prev != MD_WRITE);
    end
    if (pif.en && pif.md == MD_VERIFY) begin
      d.re = 1'b1;
      d.bus_oe = 1'b1;
      d.bus_out = prom_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pif.addr = q.addr;
  assign pif.wdata = q.wdata;
  assign pif.we = q.we;
  assign pif.re = q.re;
  assign pif.bus_out = q.bus_out;
  assign pif.bus_oe = q.bus_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_addr_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pif.en && pif.md != MD_CLEAR && rise && q.cnt == CLK_PER_ADDR_M1)
    |=> q.addr == $past(q.addr) + 12'h001)
    else $error("address did not advance on fourth clock");
  chk_verify_drive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pif.en && pif.md == MD_VERIFY) |=> pif.bus_oe && pif.re)
    else $error("verify mode did not drive the data bus");
  chk_clear_addr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pif.en && pif.md == MD_CLEAR) |=> q.addr == 12'h000)
    else $error("clear mode did not zero the address");
endmodule // nbp_prog_ctl

// ===== hdl/nbp_port_top.sv
// Purpose: Pin logic of six ports with alternate and programming roles.
// Assumes: APB slave, no wait state; pads resolve out/oe/pull-ups.
// Notes:   Every pad output comes from a flip-flop; pins pass two flops.
// Function
// - The analog-shared port has direction chosen bit by bit.
// - Ports a, b and the open-drain nibble port set direction per nibble.
// - Those three ports have one pull-up enable for all four bits.
// - The multifunction open-drain port has direction chosen per bit.
// - The multifunction open-drain port has a pull-up enable per bit.
// - A 2-bit input-only port shares pins with release and reference.
// - Port d bits 3..0 carry timer out, serial in, serial out, clock.
// - Bit 0 of the 2-bit port also releases the device from standby.
// - The interrupt pin raises a request and also releases standby.
// - In programming mode four pins select the memory operation.
// - In programming mode eight pins form a two-way data bus.
// - High voltage on reset or release pin selects test or prog mode.
// - The address advances once every four address clock pulses.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module nbp_port_top
  import nbp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Nibble ports a and b, push-pull
  input  wire logic [3:0]  nibble_port_a_in,
  output logic      [3:0]  nibble_port_a_out,
  output logic      [3:0]  nibble_port_a_oe,
  output logic             nibble_port_a_pu,
  input  wire logic [3:0]  nibble_port_b_in,
  output logic      [3:0]  nibble_port_b_out,
  output logic      [3:0]  nibble_port_b_oe,
  output logic             nibble_port_b_pu,
  // Analog-shared port, push-pull
  input  wire logic [3:0]  analog_shared_port_in,
  output logic      [3:0]  analog_shared_port_out,
  output logic      [3:0]  analog_shared_port_oe,
  // Multifunction open-drain port
  input  wire logic [3:0]  multifunction_od_port_in,
  output logic      [3:0]  multifunction_od_port_out,
  output logic      [3:0]  multifunction_od_port_oe,
  output logic      [3:0]  multifunction_od_port_pu,
  // Open-drain nibble port
  input  wire logic [3:0]  open_drain_nibble_port_in,
  output logic      [3:0]  open_drain_nibble_port_out,
  output logic      [3:0]  open_drain_nibble_port_oe,
  output logic             open_drain_nibble_port_pu,
  // Input-only pins and detectors
  input  wire logic [1:0]  two_bit_input_port_in,
  input  wire logic        ext_int_in,
  input  wire logic        hv_on_reset_pin,
  input  wire logic        hv_on_release_pin,
  input  wire logic        prog_addr_clk_in,
  // Core side
  input  wire logic        timer1_carry_out,
  input  wire logic        serial_data_out,
  input  wire logic        serial_clk_out,
  input  wire logic        serial_clk_oe,
  output logic             serial_data_in,
  output logic             serial_clk_in,
  output logic             standby_release,
  output logic             ext_int_req,
  output logic             test_mode,
  output logic             prog_mode,
  // Program memory
  input  wire logic [7:0]  prom_rdata,
  output logic      [11:0] prom_addr,
  output logic      [7:0]  prom_wdata,
  output logic             prom_we,
  output logic             prom_re
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic [2:0]      nib_dir;
    logic [2:0]      nib_pu;
    logic [3:0]      c_dir;
    logic [3:0]      d_dir;
    logic [3:0]      d_pu;
    logic [3:0]      d_alt;
    logic [19:0]     dout;
    logic [1:0]      evt;
    logic            int_prev;
    logic            int_req;
    logic            rel;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [3:0]      a_out, a_oe, b_out, b_oe, c_out, c_oe;
    logic [3:0]      d_oe, d_pu_o, e_oe, od_low;
    logic            a_pu, b_pu, e_pu;
    logic            si, sck;
  } nbp_top_type;

  nbp_top_type q, d;
  nbp_prog_if  pif ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic        wr, pm, rel_now;
  logic [3:0]  d_drv;
  logic [1:0]  evt_clr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = {prog_addr_clk_in, hv_on_release_pin, hv_on_reset_pin,
            ext_int_in, two_bit_input_port_in, open_drain_nibble_port_in,
            multifunction_od_port_in, analog_shared_port_in,
            nibble_port_b_in, nibble_port_a_in};
    d.s2 = q.s1;
    pm = q.s2[SY_HVP];
    wr = psel & penable & q.pready & pwrite;
    evt_clr = 2'h0;
    // Register writes.
    if (wr && hit(paddr, OFF_NIB_CTRL)) begin
      d.nib_dir = pwdata[NIB_DIR_LSB +: 3];
      d.nib_pu = pwdata[NIB_PU_LSB +: 3];
    end
    if (wr && hit(paddr, OFF_C_DIR)) begin
      d.c_dir = pwdata[3:0];
    end
    if (wr && hit(paddr, OFF_D_CTRL)) begin
      d.d_dir = pwdata[D_DIR_LSB +: 4];
      d.d_pu = pwdata[D_PU_LSB +: 4];
      d.d_alt = pwdata[D_ALT_LSB +: 4];
    end
    if (wr && hit(paddr, OFF_DATA_OUT)) begin
      d.dout = pwdata[19:0];
    end
    if (wr && hit(paddr, OFF_EVENT)) begin
      evt_clr = pwdata[1:0];
    end
    // Standby release and interrupt request from the sampled pins.
    rel_now = ~pm & (q.s2[SY_F] | q.s2[SY_INT]);
    d.rel = rel_now;
    d.int_prev = q.s2[SY_INT];
    d.int_req = ~pm & q.s2[SY_INT] & ~q.int_prev;
    // A new event beats a clear in the same cycle.
    d.evt[EVT_REL] = (q.evt[EVT_REL] & ~evt_clr[EVT_REL])
                     | (rel_now & ~q.rel);
    d.evt[EVT_INT] = (q.evt[EVT_INT] & ~evt_clr[EVT_INT]) | d.int_req;
    // APB answer, prepared in the setup cycle.
    d.pready = psel & ~penable;
    d.pslverr = 1'b0;
    d.prdata = 32'h00000000;
    if (psel && !penable) begin
      unique case (1'b1)
        hit(paddr, OFF_NIB_CTRL):
          d.prdata = {25'h0, q.nib_pu, 1'b0, q.nib_dir};
        hit(paddr, OFF_C_DIR):    d.prdata = {28'h0, q.c_dir};
        hit(paddr, OFF_D_CTRL):
          d.prdata = {20'h0, q.d_alt, q.d_pu, q.d_dir};
        hit(paddr, OFF_DATA_OUT): d.prdata = {12'h0, q.dout};
        hit(paddr, OFF_PIN_IN):
          d.prdata = {7'h0, q.s2[SY_HVP:SY_A]};
        hit(paddr, OFF_EVENT):    d.prdata = {30'h0, q.evt};
        default:                  d.pslverr = 1'b1;
      endcase
    end
    // Port d: open drain, alternates override the port latch.
    d_drv = q.d_dir & ~q.dout[15:12];
    if (q.d_alt[ALT_TM1]) begin
      d_drv[3] = ~timer1_carry_out;
    end
    if (q.d_alt[ALT_SI]) begin
      d_drv[2] = 1'b0;
    end
    if (q.d_alt[ALT_SO]) begin
      d_drv[1] = ~serial_data_out;
    end
    if (q.d_alt[ALT_SCK]) begin
      d_drv[0] = serial_clk_oe & ~serial_clk_out;
    end
    d.si = q.d_alt[ALT_SI] & q.s2[SY_D + 2];
    d.sck = q.d_alt[ALT_SCK] & q.s2[SY_D];
    d.od_low = 4'h0;
    // Pad drive in normal mode.
    d.a_out = q.dout[3:0];
    d.b_out = q.dout[7:4];
    d.c_out = q.dout[11:8];
    d.a_oe = {4{q.nib_dir[0]}};
    d.b_oe = {4{q.nib_dir[1]}};
    d.e_oe = {4{q.nib_dir[2]}} & ~q.dout[19:16];
    d.c_oe = q.c_dir;
    d.d_oe = d_drv;
    d.a_pu = q.nib_pu[0];
    d.b_pu = q.nib_pu[1];
    d.e_pu = q.nib_pu[2];
    d.d_pu_o = q.d_pu;
    // Programming mode takes the pins over.
    if (pm) begin
      d.a_out = pif.bus_out[3:0];
      d.b_out = pif.bus_out[7:4];
      d.a_oe = {4{pif.bus_oe}};
      d.b_oe = {4{pif.bus_oe}};
      d.c_oe = 4'h0;
      d.d_oe = 4'h0;
      d.e_oe = 4'h0;
      d.a_pu = 1'b0;
      d.b_pu = 1'b0;
      d.e_pu = 1'b0;
      d.d_pu_o = 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.nib_dir <= RST_NIB;
      q.c_dir <= RST_BITS;
      q.d_dir <= RST_BITS;
      q.d_alt <= RST_BITS;
      q.dout <= RST_DOUT;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Programming control
  // ----------------------------------------------------------------
  assign pif.en = q.s2[SY_HVP];
  assign pif.md = q.s2[SY_C +: 4];
  assign pif.clk_lvl = q.s2[SY_PCLK];
  assign pif.bus_in = {q.s2[SY_B +: 4], q.s2[SY_A +: 4]};

  nbp_prog_ctl u_prog (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .pif        (pif),
    .prom_rdata (prom_rdata)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign nibble_port_a_out = q.a_out;
  assign nibble_port_a_oe = q.a_oe;
  assign nibble_port_a_pu = q.a_pu;
  assign nibble_port_b_out = q.b_out;
  assign nibble_port_b_oe = q.b_oe;
  assign nibble_port_b_pu = q.b_pu;
  assign analog_shared_port_out = q.c_out;
  assign analog_shared_port_oe = q.c_oe;
  assign multifunction_od_port_out = q.od_low;
  assign multifunction_od_port_oe = q.d_oe;
  assign multifunction_od_port_pu = q.d_pu_o;
  assign open_drain_nibble_port_out = q.od_low;
  assign open_drain_nibble_port_oe = q.e_oe;
  assign open_drain_nibble_port_pu = q.e_pu;
  assign serial_data_in = q.si;
  assign serial_clk_in = q.sck;
  assign standby_release = q.rel;
  assign ext_int_req = q.int_req;
  assign test_mode = q.s2[SY_HVR];
  assign prog_mode = q.s2[SY_HVP];
  assign prom_addr = pif.addr;
  assign prom_wdata = pif.wdata;
  assign prom_we = pif.we;
  assign prom_re = pif.re;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_c_dir_bits: assert property (
    (wr && hit(paddr, OFF_C_DIR) && !pm) ##1 !pm ##1 !pm
    |-> analog_shared_port_oe == $past(pwdata[3:0], 2))
    else $error("analog port direction not per bit");
  chk_nib_dir_whole: assert property (
    !$past(pm) |-> nibble_port_a_oe == {4{$past(q.nib_dir[0])}}
    && nibble_port_b_oe == {4{$past(q.nib_dir[1])}})
    else $error("nibble port direction split");
  chk_nib_pullup: assert property (
    (wr && hit(paddr, OFF_NIB_CTRL)) ##1 !pm ##1 !pm
    |-> open_drain_nibble_port_pu == $past(pwdata[NIB_PU_LSB + 2], 2))
    else $error("nibble pull-up not applied");
  chk_d_pullup: assert property (
    (wr && hit(paddr, OFF_D_CTRL)) ##1 !pm ##1 !pm
    |-> multifunction_od_port_pu == $past(pwdata[7:4], 2))
    else $error("port d pull-up not per bit");
  chk_si_input: assert property (
    $past(q.d_alt[ALT_SI]) && !$past(pm) |-> !multifunction_od_port_oe[2])
    else $error("serial input pin driven");
  chk_release_pin: assert property (
    $rose(q.s2[SY_F]) && !pm |=> standby_release)
    else $error("release pin did not release standby");
  chk_int_pulse: assert property (
    ext_int_req |-> standby_release ##1 !ext_int_req)
    else $error("interrupt request not a single pulse");
  chk_prog_entry: assert property (
    hv_on_release_pin [*3] |-> prog_mode)
    else $error("high voltage did not enter program mode");
  chk_apb_answer: assert property (
    psel && !penable |=> pready [*1] ##1 !pready)
    else $error("apb answer not one cycle");
  cov_prog_verify: cover property (prog_mode && prom_re);
  cov_int_event: cover property (ext_int_req ##[1:20] wr);
  cov_alt_sck: cover property (q.d_alt[ALT_SCK] && serial_clk_oe);
endmodule // nbp_port_top

// ===== verif/nbp_board_model.sv
// Purpose: Board pins and program memory seen from the port pins.
// Assumes: The bench drives a level on every pin it does not leave.
// Notes:   Open-drain bits can only pull their pin low.
`timescale 1ns/100ps
module nbp_board_model (
  // Clock
  input  wire logic        sys_clk,
  // Pad side
  input  wire logic [19:0] out,
  input  wire logic [19:0] oe,
  input  wire logic [19:0] od,
  input  wire logic [19:0] ext,
  output logic      [19:0] pin,
  // Memory side
  input  wire logic [11:0] prom_addr,
  output logic      [7:0]  prom_rdata
);
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      pin[i] = oe[i] ? (out[i] & ~od[i]) : ext[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    prom_rdata <= prom_addr[7:0] ^ 8'h5a;
  end
endmodule // nbp_board_model

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the nibble port pin logic.
// Assumes: APB answers within a few cycles; pins pass two flops.
// Notes:   Bus reads are checked from a queue of expected words.
`timescale 1ns/100ps
module testbench
  import nbp_pkg::*;
;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, prom_rdata, prom_wdata;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] nibble_port_a_in, nibble_port_a_out, nibble_port_a_oe;
  logic [3:0] nibble_port_b_in, nibble_port_b_out, nibble_port_b_oe;
  logic [3:0] analog_shared_port_in, analog_shared_port_out;
  logic [3:0] analog_shared_port_oe, multifunction_od_port_in;
  logic [3:0] multifunction_od_port_out, multifunction_od_port_oe;
  logic [3:0] multifunction_od_port_pu, open_drain_nibble_port_in;
  logic [3:0] open_drain_nibble_port_out, open_drain_nibble_port_oe;
  logic nibble_port_a_pu, nibble_port_b_pu, open_drain_nibble_port_pu;
  logic [1:0] two_bit_input_port_in;
  logic ext_int_in, hv_on_reset_pin, hv_on_release_pin, prog_addr_clk_in;
  logic timer1_carry_out, serial_data_out, serial_clk_out, serial_clk_oe;
  logic serial_data_in, serial_clk_in, standby_release, ext_int_req;
  logic test_mode, prog_mode, prom_we, prom_re;
  logic [11:0] prom_addr;
  logic [19:0] ext, pin;
  logic [32:0] q[$];
  logic [32:0] note;
  int n_mismatch, checks_done, cycles, k;

  nbp_port_top nbp_port_top_inst (.*);

  nbp_board_model nbp_board_model_inst (
    .sys_clk(sys_clk), .od(20'hff000), .ext(ext), .pin(pin),
    .out({open_drain_nibble_port_out, multifunction_od_port_out,
          analog_shared_port_out, nibble_port_b_out, nibble_port_a_out}),
    .oe({open_drain_nibble_port_oe, multifunction_od_port_oe,
         analog_shared_port_oe, nibble_port_b_oe, nibble_port_a_oe}),
    .prom_addr(prom_addr), .prom_rdata(prom_rdata));

  assign {open_drain_nibble_port_in, multifunction_od_port_in,
          analog_shared_port_in, nibble_port_b_in, nibble_port_a_in} = pin;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    n_mismatch += q.size();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t read %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t pins %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  // n address clock pulses, each long enough to pass the sync flops.
  task automatic clk_pulses(input int n);
    repeat (n) begin
      prog_addr_clk_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      prog_addr_clk_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic count_pulse(ref logic s);
    k = 0;
    repeat (6) begin
      @(posedge sys_clk);
      k += (s === 1'b1);
    end
  endtask

  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = q.pop_front();
      cmp_rd({pslverr, prdata}, note);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    void'($urandom(17187));
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {two_bit_input_port_in, ext_int_in, hv_on_reset_pin} = '0;
    {hv_on_release_pin, prog_addr_clk_in, timer1_carry_out} = '0;
    {serial_data_out, serial_clk_out, serial_clk_oe} = '0;
    ext = 20'h05000;
    do_reset();
    cmp_pin({analog_shared_port_oe, multifunction_od_port_oe}, 0);
    cmp_pin({nibble_port_a_oe, nibble_port_b_oe, serial_data_in}, 0);
    r = $urandom;
    apb(1'b1, OFF_NIB_CTRL, 32'h53);
    apb(1'b1, OFF_DATA_OUT, r);
    apb(1'b1, OFF_C_DIR, {28'h0, r[23:20]});
    apb(1'b1, OFF_D_CTRL, {20'h0, 4'h4, r[27:24], r[31:28] & 4'hb});
    repeat (3) @(posedge sys_clk);
    cmp_pin({nibble_port_a_oe, nibble_port_b_oe, open_drain_nibble_port_oe},
            12'hff0);
    cmp_pin({nibble_port_a_pu, nibble_port_b_pu, open_drain_nibble_port_pu},
            3'b101);
    cmp_pin({analog_shared_port_out, nibble_port_b_out, nibble_port_a_out},
            r[11:0]);
    cmp_pin(analog_shared_port_oe, r[23:20]);
    cmp_pin(multifunction_od_port_pu, r[27:24]);
    cmp_pin(multifunction_od_port_oe, r[31:28] & 4'hb & ~r[15:12]);
    cmp_pin(serial_data_in, 1);
    cmp_pin({multifunction_od_port_out, open_drain_nibble_port_out},
            0);
    rd(OFF_NIB_CTRL, 33'h53);
    rd(OFF_C_DIR, {29'h0, r[23:20]});
    rd(8'h18, 33'h100000000);
    {timer1_carry_out, serial_data_out, serial_clk_out, serial_clk_oe}
      <= r[3:0];
    apb(1'b1, OFF_D_CTRL, 32'h00000b00);
    repeat (5) @(posedge sys_clk);
    cmp_pin(multifunction_od_port_oe,
            {~r[3], 1'b0, ~r[2], r[0] & ~r[1]});
    cmp_pin(serial_clk_in, !(r[0] && !r[1]));
    two_bit_input_port_in <= 2'b01;
    repeat (4) @(posedge sys_clk);
    cmp_pin(standby_release, 1);
    two_bit_input_port_in <= 2'b00;
    ext_int_in <= 1'b1;
    count_pulse(ext_int_req);
    cmp_pin(k, 1);
    cmp_pin(standby_release, 1);
    rd(OFF_EVENT, 33'h3);
    apb(1'b1, OFF_EVENT, 32'h3);
    rd(OFF_EVENT, 33'h0);
    ext_int_in <= 1'b0;
    hv_on_reset_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp_pin(test_mode, 1);
    hv_on_reset_pin <= 1'b0;
    do_reset();
    cmp_pin({nibble_port_a_oe, multifunction_od_port_oe, nibble_port_a_pu},
            0);
    r = $urandom;
    hv_on_release_pin <= 1'b1;
    ext <= {8'h0, MD_CLEAR, r[7:0]};
    repeat (4) @(posedge sys_clk);
    cmp_pin(prog_mode, 1);
    cmp_pin(prom_addr, 0);
    ext <= {8'h0, MD_INHIBIT, r[7:0]};
    clk_pulses(3);
    cmp_pin(prom_addr, 0);
    clk_pulses(1);
    cmp_pin(prom_addr, 1);
    ext <= {8'h0, MD_WRITE, r[7:0]};
    count_pulse(prom_we);
    cmp_pin(k, 1);
    cmp_pin(prom_wdata, r[7:0]);
    ext <= {8'h0, MD_VERIFY, r[7:0]};
    repeat (6) @(posedge sys_clk);
    cmp_pin({nibble_port_b_oe, nibble_port_a_oe}, 8'hff);
    cmp_pin({nibble_port_b_out, nibble_port_a_out}, 8'h5b);
    cmp_pin(prom_re, 1);
    rd(OFF_PIN_IN, {9'h001, 12'h000, MD_VERIFY, 8'h5b});
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule // testbench
